// ### acb_cfg.svh
// Constants for the conversion configuration byte decoder
// Overview of operation
// - Bit 7 of a received control byte is a type flag: one is a setup byte, zero is the configuration byte.
// - Bits 6 and 5 hold the two-bit scan pattern, reset to 00.
// - On the four-input variant the two upper channel-select bits are forced to zero internally.
// - Bit 0 selects pairing, 1 single-ended and 0 differential, reset to 1.
// - Single-ended codes 0 to 1011 connect input N positive against ground; 1100 to 1111 are reserved.
// - Differential even code 2k pairs 2k positive against 2k+1; the next odd code swaps polarity.
// - With the shared pin as reference, single-ended input 3 or 11 is ignored and scans end at 2 or 10.
// - With the shared pin as reference, code 2 or 10 converts that input against ground; code 3 or 11 swaps polarity.
// - A differential scan advances the channel index by two per conversion up to the select limit.
// - Each byte written after the write address is classified by its most significant bit.
// - The shared pin is a reference and leaves scans whenever the setup reference-select bit is 1.
// - After reset the block defaults to single-ended, unipolar, single-channel input 0, internal clock.
`ifndef ACB_CFG_SVH
`define ACB_CFG_SVH
`define ACB_TYPE_BIT      7
`define ACB_SCAN_HI       6
`define ACB_SCAN_LO       5
`define ACB_CS_HI         4
`define ACB_CS_LO         1
`define ACB_PAIR_BIT      0
`define ACB_SETUP_REF_BIT 5
`define ACB_SETUP_CLK_BIT 3
`define ACB_SETUP_BIP_BIT 2
`define ACB_SETUP_RST_BIT 1
`define ACB_SCAN_RST      2'h0
`define ACB_CS_RST        4'h0
`define ACB_PAIR_RST      1'h1
`define ACB_SETUP_RST     8'h82
`define ACB_CS_LAST       4'hB
`define ACB_GND_SEL       4'hF
`endif

// ### acb_pkg.sv
// Types for the conversion configuration byte decoder
package acb_pkg;
   typedef enum logic [1:0] {
      ACB_IDLE = 2'b00,
      ACB_SCAN = 2'b01,
      ACB_DONE = 2'b10
   } acb_state_t;

   typedef struct packed {
      logic [1:0] sweep_pattern;
      logic [3:0] chan_pick;
      logic       input_pairing_sel;
      logic [7:0] setup;
   } acb_cfg_t;
endpackage

// ### acb_pair_if.sv
// Input pair selection travelling between the decoder's scan stepper and the pair map
`timescale 1ns/10ps
interface acb_pair_if;
   logic [3:0] index;
   logic       valid;
   logic [3:0] pos;
   logic [3:0] neg;
   logic       pos_gnd;
   logic       neg_gnd;
   logic       dif;
   logic       ref_claim;
   modport step (output index, input valid, pos, neg, pos_gnd, neg_gnd);
   modport map  (input index, dif, ref_claim,
                 output valid, pos, neg, pos_gnd, neg_gnd);
endinterface

// ### acb_pair_map.sv
// Maps a channel index and pairing mode onto a positive and negative input
`timescale 1ns/10ps
`include "acb_cfg.svh"
module acb_pair_map
   import acb_pkg::*;
#(
   parameter int NUM_INPUTS = 12   // 4 or 12 analog inputs
)(
   acb_pair_if.map p   // Pair lookup
);
   // Only the four-input and twelve-input variants are served
   if (NUM_INPUTS != 4 && NUM_INPUTS != 12) begin : g_bad_inputs
      $error("NUM_INPUTS must be 4 or 12");
   end

   // Highest input doubles as the shared reference pin
   localparam logic [3:0] REF_IDX = 4'(NUM_INPUTS - 1);

   // Lookup of the input pair for the index offered
   always_comb begin
      p.valid   = 1'b1;
      p.pos     = p.index;
      p.neg     = `ACB_GND_SEL;
      p.pos_gnd = 1'b0;
      p.neg_gnd = 1'b1;
      if (p.index > `ACB_CS_LAST) begin
         p.valid   = 1'b0;
         p.neg_gnd = 1'b0;
      end else if (!p.dif) begin
         // Shared pin claimed as reference cannot be converted alone
         if (p.ref_claim && p.index == REF_IDX)
            p.valid = 1'b0;
      end else begin
         p.neg_gnd = 1'b0;
         p.neg     = {p.index[3:1], ~p.index[0]};
         if (p.ref_claim && p.index[3:1] == REF_IDX[3:1]) begin
            // Shared pin is reference: ground stands in for the odd input
            if (p.index[0]) begin
               p.pos     = `ACB_GND_SEL;
               p.pos_gnd = 1'b1;
               p.neg     = {p.index[3:1], 1'b0};
            end else begin
               p.neg     = `ACB_GND_SEL;
               p.neg_gnd = 1'b1;
            end
         end
      end
   end
endmodule

// ### acb_config_decoder.sv
// Configuration byte decoder with scan stepping toward the converter
`timescale 1ns/10ps
`include "acb_cfg.svh"
module acb_config_decoder
   import acb_pkg::*;
#(
   parameter int NUM_INPUTS = 12   // 4 or 12 analog inputs
)(
   input  wire logic       mclk,          // Clock
   input  wire logic       rst,           // Synchronous reset
   input  wire logic       byte_valid,    // Byte after write address
   input  wire logic [7:0] byte_data,     // Received byte
   input  wire logic       conv_start,    // Start a conversion sequence
   input  wire logic       conv_done,     // Current conversion finished
   output logic [1:0]      sweep_pattern, // Stored scan pattern
   output logic [3:0]      chan_pick,     // Effective channel select
   output logic            input_pairing_sel, // 1 single-ended
   output logic            ref_pin_claim, // Shared pin is reference
   output logic            bipolar,       // Bipolar coding
   output logic            ext_clock,     // External conversion clock
   output logic            conv_active,   // Conversion in progress
   output logic [3:0]      conv_pos,      // Positive input index
   output logic [3:0]      conv_neg,      // Negative input index
   output logic            conv_pos_gnd,  // Positive input is ground
   output logic            conv_neg_gnd,  // Negative input is ground
   output logic            conv_valid,    // Pair is meaningful
   output logic            scan_end       // Last channel of scan
);
   // Only the four-input and twelve-input variants are served
   if (NUM_INPUTS != 4 && NUM_INPUTS != 12) begin : g_bad_inputs
      $error("NUM_INPUTS must be 4 or 12");
   end

   // Highest input doubles as the shared reference pin
   localparam logic [3:0] REF_IDX = 4'(NUM_INPUTS - 1);

   typedef struct packed {
      acb_cfg_t   cfg;
      acb_state_t st;
      logic [3:0] idx;
      logic [3:0] lim;
      logic       last;
   } acb_reg_t;

   acb_reg_t   q_r;
   acb_reg_t   q_nxt;
   logic [3:0] cs_eff;
   logic [3:0] lim_c;
   logic [3:0] first_c;
   acb_pair_if pif ();

   acb_pair_map #(.NUM_INPUTS(NUM_INPUTS)) u_map (
      .p (pif.map)
   );

   // Forced upper select bits on the small variant
   assign cs_eff = (NUM_INPUTS == 4) ?
                   {2'b00, q_r.cfg.chan_pick[1:0]} : q_r.cfg.chan_pick;
   assign pif.dif       = ~q_r.cfg.input_pairing_sel;
   assign pif.ref_claim = q_r.cfg.setup[`ACB_SETUP_REF_BIT];
   assign pif.index     = q_r.idx;

   // Scan start and limit for the stored pattern
   always_comb begin
      first_c = 4'h0;
      lim_c   = cs_eff;
      if (cs_eff > `ACB_CS_LAST)
         lim_c = `ACB_CS_LAST;
      unique case (q_r.cfg.sweep_pattern)
         2'b00: first_c = 4'h0;
         2'b10: first_c = (NUM_INPUTS == 4) ? 4'h2 : 4'h6;
         default: begin
            first_c = cs_eff;
            lim_c   = cs_eff;
         end
      endcase
      if (lim_c < first_c)
         lim_c = first_c;
      // A single-ended scan over several channels stops short of the shared pin while it is a reference
      if (pif.ref_claim && !pif.dif && q_r.cfg.sweep_pattern[0] == 1'b0
          && lim_c == REF_IDX)
         lim_c = lim_c - 4'h1;
      // Differential scans walk even codes; a single odd code keeps its swap
      if (pif.dif && q_r.cfg.sweep_pattern[0] == 1'b0) begin
         first_c = {first_c[3:1], 1'b0};
         lim_c   = {lim_c[3:1], 1'b0};
      end
   end

   // Byte capture and scan sequencing
   always_comb begin
      q_nxt = q_r;
      if (byte_valid) begin
         if (!byte_data[`ACB_TYPE_BIT]) begin
            q_nxt.cfg.sweep_pattern =
               byte_data[`ACB_SCAN_HI:`ACB_SCAN_LO];
            q_nxt.cfg.chan_pick = byte_data[`ACB_CS_HI:`ACB_CS_LO];
            q_nxt.cfg.input_pairing_sel = byte_data[`ACB_PAIR_BIT];
         end else begin
            q_nxt.cfg.setup = byte_data;
            if (!byte_data[`ACB_SETUP_RST_BIT]) begin
               q_nxt.cfg.sweep_pattern     = `ACB_SCAN_RST;
               q_nxt.cfg.chan_pick         = `ACB_CS_RST;
               q_nxt.cfg.input_pairing_sel = `ACB_PAIR_RST;
            end
         end
      end
      unique case (q_r.st)
         ACB_IDLE: begin
            if (conv_start) begin
               q_nxt.st   = ACB_SCAN;
               q_nxt.idx  = first_c;
               q_nxt.lim  = lim_c;
               q_nxt.last = (first_c >= lim_c);
            end
         end
         ACB_SCAN: begin
            if (conv_done) begin
               if (q_r.last) begin
                  q_nxt.st = ACB_DONE;
               end else begin
                  // Differential scans step over the partner input
                  q_nxt.idx  = pif.dif ? q_r.idx + 4'h2 : q_r.idx + 4'h1;
                  q_nxt.last = ((pif.dif ? q_r.idx + 4'h2 : q_r.idx + 4'h1)
                                >= q_r.lim);
               end
            end
         end
         ACB_DONE: q_nxt.st = ACB_IDLE;
         default:  q_nxt.st = ACB_IDLE;
      endcase
      if (rst) begin
         q_nxt.cfg.sweep_pattern     = `ACB_SCAN_RST;
         q_nxt.cfg.chan_pick         = `ACB_CS_RST;
         q_nxt.cfg.input_pairing_sel = `ACB_PAIR_RST;
         q_nxt.cfg.setup             = `ACB_SETUP_RST;
         q_nxt.st   = ACB_IDLE;
         q_nxt.idx  = 4'h0;
         q_nxt.lim  = 4'h0;
         q_nxt.last = 1'b0;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      q_r <= q_nxt;
   end

   // Outputs
   assign sweep_pattern     = q_r.cfg.sweep_pattern;
   assign chan_pick         = cs_eff;
   assign input_pairing_sel = q_r.cfg.input_pairing_sel;
   assign ref_pin_claim     = pif.ref_claim;
   assign bipolar           = q_r.cfg.setup[`ACB_SETUP_BIP_BIT];
   assign ext_clock         = q_r.cfg.setup[`ACB_SETUP_CLK_BIT];
   assign conv_active       = (q_r.st == ACB_SCAN);
   assign conv_pos          = pif.pos;
   assign conv_neg          = pif.neg;
   assign conv_pos_gnd      = pif.pos_gnd;
   assign conv_neg_gnd      = pif.neg_gnd;
   assign conv_valid        = pif.valid & conv_active;
   assign scan_end          = conv_active & q_r.last;
endmodule

// ### acb_host.sv
// Bus master model handing bytes to the decoder
`timescale 1ns/10ps
module acb_host (
   input  logic       mclk,       // Clock
   output logic       byte_valid, // Byte strobe
   output logic [7:0] byte_data   // Byte value
);
   // Idle with no byte offered
   initial begin
      byte_valid = 1'b0;
      byte_data  = 8'h00;
   end
   // One byte after the write address; released data shows its inverse
   task automatic put(input logic [7:0] b);
      @(posedge mclk);
      #1 {byte_valid, byte_data} = {1'b1, b};
      @(posedge mclk);
      #1 {byte_valid, byte_data} = {1'b0, ~b};
   endtask
endmodule

// ### acb_config_decoder_chk.sv
// Port checker for the configuration byte decoder
`timescale 1ns/10ps
module acb_config_decoder_chk #(
   parameter int NUM_INPUTS = 12 // Input count
)(
   input logic       mclk,              // Clock
   input logic       rst,               // Reset
   input logic       byte_valid,        // Byte strobe
   input logic [7:0] byte_data,         // Byte
   input logic       conv_done,         // Done
   input logic [1:0] sweep_pattern,     // Scan
   input logic [3:0] chan_pick,         // Select
   input logic       input_pairing_sel, // Pairing
   input logic       ref_pin_claim,     // Ref
   input logic       conv_active,       // Active
   input logic [3:0] conv_pos,          // Pos
   input logic [3:0] conv_neg,          // Neg
   input logic       conv_pos_gnd,      // Pos ground
   input logic       conv_neg_gnd,      // Neg ground
   input logic       conv_valid,        // Valid
   input logic       scan_end           // Last
);
   localparam logic [3:0] REFP = 4'(NUM_INPUTS - 1);
   localparam logic [6:0] MSK = (NUM_INPUTS == 4) ? 7'h67 : 7'h7F;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Configuration byte arriving on the byte strobe
   sequence s_cfg_wr;
      byte_valid && !byte_data[7];
   endsequence
   // Final conversion of a scan being finished
   sequence s_last;
      conv_active && scan_end && conv_done;
   endsequence
   a_cfg_store: assert property (
      s_cfg_wr |=> {sweep_pattern, chan_pick, input_pairing_sel}
                   == ($past(byte_data[6:0]) & MSK))
      else $error("config fields not stored");
   a_setup_keep: assert property (
      byte_valid && byte_data[7] && byte_data[1]
      |=> $stable({sweep_pattern, chan_pick})
          && ref_pin_claim == $past(byte_data[5]))
      else $error("setup byte disturbed config");
   a_se_ground: assert property (
      conv_valid && input_pairing_sel |-> conv_neg_gnd && !conv_pos_gnd)
      else $error("single-ended pair wrong");
   a_dif_pair: assert property (
      conv_valid && !input_pairing_sel && !ref_pin_claim
      |-> conv_pos[3:1] == conv_neg[3:1] && conv_pos[0] != conv_neg[0])
      else $error("differential pair wrong");
   a_ref_skip: assert property (
      conv_active && input_pairing_sel && ref_pin_claim && conv_pos == REFP
      |-> !conv_valid)
      else $error("shared pin converted");
   a_dif_step: assert property (
      conv_active && !input_pairing_sel && !ref_pin_claim && conv_done
      && !scan_end |=> conv_pos[3:1] == $past(conv_pos[3:1]) + 3'h1)
      else $error("differential step not two");
   a_reserved_none: assert property (
      conv_active && sweep_pattern[0] && chan_pick > 4'hB |-> !conv_valid)
      else $error("reserved code valid");
   a_last_done: assert property (s_last |=> !conv_active)
      else $error("scan did not end");
endmodule
bind acb_config_decoder acb_config_decoder_chk #(.NUM_INPUTS(NUM_INPUTS))
   u_chk (
   .mclk(mclk), .rst(rst), .byte_valid(byte_valid), .byte_data(byte_data),
   .conv_done(conv_done), .sweep_pattern(sweep_pattern), .chan_pick(chan_pick),
   .input_pairing_sel(input_pairing_sel), .ref_pin_claim(ref_pin_claim),
   .conv_active(conv_active), .conv_pos(conv_pos), .conv_neg(conv_neg),
   .conv_pos_gnd(conv_pos_gnd), .conv_neg_gnd(conv_neg_gnd),
   .conv_valid(conv_valid), .scan_end(scan_end));

// ### adc_config_byte_channel_select_tb.sv
// Self-checking bench for the configuration byte decoder
`timescale 1ns/10ps
module adc_config_byte_channel_select_tb;
   logic       mclk, rst, conv_start, conv_done, byte_valid;
   logic [7:0] byte_data;
   logic [1:0] sweep_pattern;
   logic [3:0] chan_pick, conv_pos, conv_neg, chan_pick4;
   logic       input_pairing_sel, ref_pin_claim, bipolar, ext_clock;
   logic       conv_active, conv_pos_gnd, conv_neg_gnd, conv_valid, scan_end;
   int         miscompares = 0, comparisons = 0;
   // Clock
   always #2 mclk = ~mclk;
   acb_host host (.mclk(mclk), .byte_valid(byte_valid), .byte_data(byte_data));
   acb_config_decoder dut (.mclk(mclk), .rst(rst),
      .byte_valid(byte_valid), .byte_data(byte_data), .conv_start(conv_start),
      .conv_done(conv_done), .sweep_pattern(sweep_pattern),
      .chan_pick(chan_pick), .input_pairing_sel(input_pairing_sel),
      .ref_pin_claim(ref_pin_claim), .bipolar(bipolar), .ext_clock(ext_clock),
      .conv_active(conv_active), .conv_pos(conv_pos), .conv_neg(conv_neg),
      .conv_pos_gnd(conv_pos_gnd), .conv_neg_gnd(conv_neg_gnd),
      .conv_valid(conv_valid), .scan_end(scan_end));
   // Four-input variant fed the same bytes and pulses
   acb_config_decoder #(.NUM_INPUTS(4)) dut4 (.mclk(mclk), .rst(rst),
      .byte_valid(byte_valid), .byte_data(byte_data), .conv_start(conv_start),
      .conv_done(conv_done), .sweep_pattern(), .chan_pick(chan_pick4),
      .input_pairing_sel(), .ref_pin_claim(), .bipolar(), .ext_clock(),
      .conv_active(), .conv_pos(), .conv_neg(), .conv_pos_gnd(),
      .conv_neg_gnd(), .conv_valid(), .scan_end());
   // Compare and count
   task automatic chk(input logic [11:0] s, input logic [11:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, s, e);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Stored fields packed for one compare
   function automatic logic [11:0] regs();
      return {sweep_pattern, chan_pick, input_pairing_sel, ref_pin_claim,
              bipolar, ext_clock, conv_active, 1'b0};
   endfunction
   // Start (d=0) or done (d=1) pulse of one cycle
   task automatic pulse(input bit d);
      @(posedge mclk);
      #1 conv_done = d;
      conv_start = !d;
      @(posedge mclk);
      #1 conv_done = 1'b0;
      conv_start = 1'b0;
   endtask
   // Config byte, start, then walk every channel of the sequence
   task automatic scan(input logic [7:0] c, input logic [10:0] e,
                       input logic [7:0] st, input int n);
      logic [11:0] g;
      host.put(c);
      pulse(0);
      for (int k = 0; k < n; k++) begin
         g = {scan_end, conv_valid, conv_pos_gnd, conv_neg_gnd, conv_pos,
              conv_neg};
         chk(e[10] ? g : {g[11:10], 10'h0}, {k == n - 1, e});
         e[7:0] = e[7:0] + st;
         pulse(1);
      end
      chk({11'h0, conv_active}, 12'h0);
   endtask
   // Cut a hang short
   initial begin
      #100000;
      miscompares++;
      test_done;
   end
   // Main sequence
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      conv_start = 1'b0;
      conv_done = 1'b0;
      repeat (20) @(posedge mclk);
      #1 rst = 1'b0;
      chk(regs(), 12'h020);
      host.put(8'h5E);
      chk(regs(), 12'hBC0);
      chk({8'h0, chan_pick4}, 12'h003);
      host.put(8'hA6);
      chk(regs(), 12'hBD8);
      host.put(8'h88);
      chk(regs(), 12'h024);
      scan(8'h07, {3'b101, 4'h0, 4'hF}, 8'h10, 4);
      scan(8'h0A, {3'b100, 4'h0, 4'h1}, 8'h22, 3);
      scan(8'h66, {3'b100, 4'h3, 4'h2}, 8'h00, 1);
      scan(8'h53, {3'b101, 4'h6, 4'hF}, 8'h10, 4);
      host.put(8'hA2);
      scan(8'h17, {3'b101, 4'h0, 4'hF}, 8'h10, 11);
      scan(8'h77, 11'h0, 8'h00, 1);
      scan(8'h76, {3'b110, 4'hF, 4'hA}, 8'h00, 1);
      host.put(8'h82);
      scan(8'h79, 11'h0, 8'h00, 1);
      chk({8'h0, chan_pick}, 12'h00C);
      chk({8'h0, chan_pick4}, 12'h000);
      test_done;
   end
endmodule
